// >>> sbc_bank_rules.sv
`timescale 1ns/10ps
`include "sbc_map.svh"
module sbc_bank_rules
(
   input  wire logic         i_ref_clk,     // Memory clock, 20 MHz
   input  wire logic         i_resetn,      // Synchronous reset, active low
   input  wire logic         i_cke,         // Clock enable pin
   input  sbc_pkg::sbc_strobes_t i_strobes, // Chip select and strobes, active low
   input  wire logic [1:0]   i_bank,        // Bank address
   input  wire logic         i_ap,          // Auto precharge / all-banks address bit
   input  wire logic         i_sr_exit,     // Pulse: self refresh exit at this edge
   input  wire logic         i_evt_ready,   // Consumer ready for event words
   output logic              o_evt_valid,   // Event word valid
   output sbc_pkg::sbc_event_t o_evt,       // Accepted command event
   output logic [15:0]       o_bank_state,  // Four 4-bit bank states
   output logic [1:0]        o_glob_state,  // Device-wide busy state
   output logic              o_all_idle,    // Every bank idle, no busy state
   output logic              o_illegal,     // Registered: last command illegal
   output logic [1:0]        o_burst_bank,  // Registered: bank of latest burst
   output logic              o_burst_live,  // Registered: a burst is running
   output logic              o_read_bus_q,  // Registered: read owns data bus
   output logic [1:0]        o_read_bus_bank // Registered: bank owning read bus
);
   localparam int NB = `SBC_NUM_BANKS;
   localparam int CL = `SBC_READ_LATENCY;
   localparam logic [7:0] T_RP  = 8'(`SBC_PRECHARGE_CYCLES);
   localparam logic [7:0] T_WR  = 8'(`SBC_WRITE_RECOVERY_CYCLES);
   localparam logic [7:0] T_RCD = 8'(`SBC_ACT_TO_ACCESS_CYCLES);
   localparam logic [7:0] T_RFC = 8'(`SBC_REFRESH_CYCLES);
   localparam logic [7:0] T_MRD = 8'(`SBC_MODE_REG_DELAY_CK);
   localparam logic [7:0] T_XSR = 8'(`SBC_SR_EXIT_CYCLES);

   // ****************************************
   // Command decode
   // ****************************************
   logic cke_prev_q, cke_prev_d;
   logic [7:0] xsr_cnt_q, xsr_cnt_d;
   sbc_pkg::sbc_cmd_t cmd;
   logic enabled;

   // Table only valid with clock enable high on two edges and exit time met
   always_comb
   begin
      cke_prev_d = i_cke;
      xsr_cnt_d  = xsr_cnt_q;
      if (i_sr_exit)
         xsr_cnt_d = T_XSR;
      else if (xsr_cnt_q != 8'h00)
         xsr_cnt_d = xsr_cnt_q - 8'h01;
      enabled = cke_prev_q && i_cke && (xsr_cnt_q == 8'h00) && !i_sr_exit;
      cmd = sbc_pkg::CMD_IGNORED;
      if (enabled && i_strobes.cs_n)
         cmd = sbc_pkg::CMD_INHIBIT;
      else if (cke_prev_q && !i_cke && !i_strobes.cs_n &&
               {i_strobes.ras_n, i_strobes.cas_n, i_strobes.we_n} == 3'b110)
         cmd = sbc_pkg::CMD_DEEP_PD;
      else if (enabled)
      begin
         case ({i_strobes.ras_n, i_strobes.cas_n, i_strobes.we_n})
            3'b111:  cmd = sbc_pkg::CMD_NOP;
            3'b011:  cmd = sbc_pkg::CMD_ACTIVATE;
            3'b101:  cmd = sbc_pkg::CMD_READ;
            3'b100:  cmd = sbc_pkg::CMD_WRITE;
            3'b010:  cmd = sbc_pkg::CMD_PRECHARGE;
            3'b001:  cmd = sbc_pkg::CMD_REFRESH;
            3'b000:  cmd = sbc_pkg::CMD_LOAD_MODE;
            3'b110:  cmd = sbc_pkg::CMD_BURST_STOP;
            default: cmd = sbc_pkg::CMD_NOP;
         endcase
      end
   end

   // ****************************************
   // Global and per-bank state
   // ****************************************
   sbc_pkg::sbc_glob_state_t glob_q, glob_d;
   logic [7:0] glob_cnt_q, glob_cnt_d;
   sbc_pkg::sbc_bank_state_t bst_q [NB];
   sbc_pkg::sbc_bank_state_t bst_d [NB];
   logic [7:0] bcnt_q [NB];
   logic [7:0] bcnt_d [NB];
   logic [1:0] burst_bank_q, burst_bank_d;
   logic burst_live_q, burst_live_d;
   logic illegal_q, illegal_d;
   logic [NB-1:0] idle_vec, pre_ok_vec;
   logic busy;
   logic is_burst;
   logic accept;

   assign busy     = (glob_q != sbc_pkg::GL_NORMAL);
   assign is_burst = (cmd == sbc_pkg::CMD_READ) || (cmd == sbc_pkg::CMD_WRITE);

   // Per-bank idle and precharge-readiness flags
   genvar gb;
   generate
      for (gb = 0; gb < NB; gb++)
      begin : g_flags
         assign idle_vec[gb]   = (bst_q[gb] == sbc_pkg::BK_IDLE);
         assign pre_ok_vec[gb] = (bst_q[gb] == sbc_pkg::BK_IDLE) || (bst_q[gb] == sbc_pkg::BK_ACTIVE) ||
                                 (bst_q[gb] == sbc_pkg::BK_READ) || (bst_q[gb] == sbc_pkg::BK_WRITE);
      end
   endgenerate

   // Device-wide busy states, legality check
   always_comb
   begin
      glob_d     = glob_q;
      glob_cnt_d = glob_cnt_q;
      illegal_d  = 1'b0;
      accept     = 1'b0;
      if (busy)
      begin
         if (cmd != sbc_pkg::CMD_NOP && cmd != sbc_pkg::CMD_INHIBIT && cmd != sbc_pkg::CMD_IGNORED)
            illegal_d = 1'b1;
         if (glob_cnt_q <= 8'h01)
            glob_d = sbc_pkg::GL_NORMAL;
         else
            glob_cnt_d = glob_cnt_q - 8'h01;
      end
      else
      begin
         case (cmd)
            sbc_pkg::CMD_REFRESH, sbc_pkg::CMD_LOAD_MODE:
            begin
               if (&idle_vec)
               begin
                  accept     = 1'b1;
                  glob_d     = (cmd == sbc_pkg::CMD_REFRESH) ? sbc_pkg::GL_REFRESHING : sbc_pkg::GL_MODE_ACCESS;
                  glob_cnt_d = (cmd == sbc_pkg::CMD_REFRESH) ? T_RFC : T_MRD;
               end
               else
                  illegal_d = 1'b1;
            end
            sbc_pkg::CMD_PRECHARGE:
            begin
               if (i_ap && !(&pre_ok_vec))
                  illegal_d = 1'b1;
               else
               begin
                  accept = 1'b1;
                  if (i_ap)
                  begin
                     glob_d     = sbc_pkg::GL_PRECHARGE_ALL;
                     glob_cnt_d = T_RP;
                  end
               end
            end
            sbc_pkg::CMD_ACTIVATE:
            begin
               accept    = (bst_q[i_bank] == sbc_pkg::BK_IDLE);
               illegal_d = !accept;
            end
            sbc_pkg::CMD_READ, sbc_pkg::CMD_WRITE:
            begin
               accept = (bst_q[i_bank] == sbc_pkg::BK_ACTIVE) || (bst_q[i_bank] == sbc_pkg::BK_READ) ||
                        (bst_q[i_bank] == sbc_pkg::BK_WRITE);
               illegal_d = !accept;
            end
            sbc_pkg::CMD_BURST_STOP:
               accept = burst_live_q;
            default:
               accept = 1'b0;
         endcase
      end
   end

   // Per-bank next state, including concurrent auto precharge
   always_comb
   begin
      burst_bank_d = burst_bank_q;
      burst_live_d = burst_live_q;
      for (int b = 0; b < NB; b++)
      begin
         bst_d[b]  = bst_q[b];
         bcnt_d[b] = (bcnt_q[b] != 8'h00) ? bcnt_q[b] - 8'h01 : 8'h00;
         case (bst_q[b])
            sbc_pkg::BK_ACTIVATING:
               if (bcnt_q[b] <= 8'h01)
                  bst_d[b] = sbc_pkg::BK_ACTIVE;
            sbc_pkg::BK_PRECHARGING, sbc_pkg::BK_READ_AP, sbc_pkg::BK_WRITE_AP:
               if (bcnt_q[b] <= 8'h01 && bst_q[b] == sbc_pkg::BK_PRECHARGING)
                  bst_d[b] = sbc_pkg::BK_IDLE;
            sbc_pkg::BK_RECOVERY:
               if (bcnt_q[b] <= 8'h01)
               begin
                  bst_d[b]  = sbc_pkg::BK_PRECHARGING;
                  bcnt_d[b] = T_RP;
               end
            default:
               bst_d[b] = bst_q[b];
         endcase
      end
      if (glob_q == sbc_pkg::GL_PRECHARGE_ALL && glob_cnt_q <= 8'h01)
         for (int b = 0; b < NB; b++)
            bst_d[b] = sbc_pkg::BK_IDLE;
      if (accept)
      begin
         case (cmd)
            sbc_pkg::CMD_ACTIVATE:
            begin
               bst_d[i_bank]  = sbc_pkg::BK_ACTIVATING;
               bcnt_d[i_bank] = T_RCD;
            end
            sbc_pkg::CMD_PRECHARGE:
               for (int b = 0; b < NB; b++)
                  if ((i_ap || 2'(b) == i_bank) && bst_q[b] != sbc_pkg::BK_IDLE)
                  begin
                     bst_d[b]  = sbc_pkg::BK_PRECHARGING;
                     bcnt_d[b] = T_RP;
                  end
            sbc_pkg::CMD_READ, sbc_pkg::CMD_WRITE:
            begin
               // Interrupted auto-precharge banks start their own precharge, write banks only after write recovery
               for (int b = 0; b < NB; b++)
                  if (2'(b) != i_bank)
                  begin
                     if (bst_q[b] == sbc_pkg::BK_READ_AP)
                     begin
                        bst_d[b]  = sbc_pkg::BK_PRECHARGING;
                        bcnt_d[b] = T_RP;
                     end
                     else if (bst_q[b] == sbc_pkg::BK_WRITE_AP)
                     begin
                        bst_d[b]  = sbc_pkg::BK_RECOVERY;
                        bcnt_d[b] = T_WR;
                     end
                     else if (bst_q[b] == sbc_pkg::BK_READ || bst_q[b] == sbc_pkg::BK_WRITE)
                        bst_d[b] = sbc_pkg::BK_ACTIVE;
                  end
               if (cmd == sbc_pkg::CMD_READ)
                  bst_d[i_bank] = i_ap ? sbc_pkg::BK_READ_AP : sbc_pkg::BK_READ;
               else
                  bst_d[i_bank] = i_ap ? sbc_pkg::BK_WRITE_AP : sbc_pkg::BK_WRITE;
               bcnt_d[i_bank] = 8'h00;
               burst_bank_d   = i_bank;
               burst_live_d   = 1'b1;
            end
            sbc_pkg::CMD_BURST_STOP:
            begin
               burst_live_d = 1'b0;
               if (bst_q[burst_bank_q] == sbc_pkg::BK_READ || bst_q[burst_bank_q] == sbc_pkg::BK_WRITE)
                  bst_d[burst_bank_q] = sbc_pkg::BK_ACTIVE;
            end
            default:
               burst_live_d = burst_live_q;
         endcase
      end
   end

   // ****************************************
   // Read data bus ownership pipeline
   // ****************************************
   logic [CL-1:0] rd_pipe_q, rd_pipe_d;
   logic [2*CL-1:0] rd_bank_pipe_q, rd_bank_pipe_d;

   // Newest read owns the bus two clocks (read latency minus one) after it is registered; a write drops it at once
   always_comb
   begin
      rd_pipe_d      = {rd_pipe_q[CL-2:0], (accept && cmd == sbc_pkg::CMD_READ)};
      rd_bank_pipe_d = {rd_bank_pipe_q[2*CL-3:0], i_bank};
      if (accept && cmd == sbc_pkg::CMD_WRITE)
         rd_pipe_d = '0;
   end

   // ****************************************
   // Two-entry event buffer
   // ****************************************
   sbc_pkg::sbc_event_t buf_q [`SBC_BUF_DEPTH];
   sbc_pkg::sbc_event_t buf_d [`SBC_BUF_DEPTH];
   logic [1:0] cnt_q, cnt_d;
   logic push, pop;

   // A full buffer drops the newest event when two already wait and none leaves in that cycle
   assign pop  = o_evt_valid && i_evt_ready;
   assign push = accept && (cnt_q != 2'h2 || pop);
   always_comb
   begin
      buf_d = buf_q;
      cnt_d = cnt_q;
      if (pop)
      begin
         buf_d[0] = buf_q[1];
         cnt_d    = cnt_d - 2'h1;
      end
      if (push)
      begin
         buf_d[cnt_d[0]] = '{cmd: cmd, bank: i_bank, ap: i_ap};
         cnt_d           = cnt_d + 2'h1;
      end
   end

   // Register all state
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         cke_prev_q     <= 1'b0;
         xsr_cnt_q      <= 8'h00;
         glob_q         <= sbc_pkg::GL_NORMAL;
         glob_cnt_q     <= 8'h00;
         burst_bank_q   <= 2'h0;
         burst_live_q   <= 1'b0;
         illegal_q      <= 1'b0;
         rd_pipe_q      <= '0;
         rd_bank_pipe_q <= '0;
         cnt_q          <= 2'h0;
         for (int b = 0; b < NB; b++)
         begin
            bst_q[b]  <= sbc_pkg::BK_IDLE;
            bcnt_q[b] <= 8'h00;
         end
         for (int e = 0; e < `SBC_BUF_DEPTH; e++)
            buf_q[e] <= '{cmd: sbc_pkg::CMD_NOP, bank: 2'h0, ap: 1'b0};
      end
      else
      begin
         cke_prev_q     <= cke_prev_d;
         xsr_cnt_q      <= xsr_cnt_d;
         glob_q         <= glob_d;
         glob_cnt_q     <= glob_cnt_d;
         burst_bank_q   <= burst_bank_d;
         burst_live_q   <= burst_live_d;
         illegal_q      <= illegal_d;
         rd_pipe_q      <= rd_pipe_d;
         rd_bank_pipe_q <= rd_bank_pipe_d;
         cnt_q          <= cnt_d;
         bst_q          <= bst_d;
         bcnt_q         <= bcnt_d;
         buf_q          <= buf_d;
      end
   end

   // Outputs
   generate
      for (gb = 0; gb < NB; gb++)
      begin : g_out
         assign o_bank_state[4*gb +: 4] = bst_q[gb];
      end
   endgenerate
   assign o_glob_state    = glob_q;
   assign o_all_idle      = (&idle_vec) && !busy;
   assign o_illegal       = illegal_q;
   assign o_burst_bank    = burst_bank_q;
   assign o_burst_live    = burst_live_q;
   assign o_read_bus_q    = rd_pipe_q[CL-1];
   assign o_read_bus_bank = rd_bank_pipe_q[2*CL-1 -: 2];
   assign o_evt_valid     = (cnt_q != 2'h0);
   assign o_evt           = buf_q[0];

   // ****************************************
   // Checks
   // ****************************************
   sequence s_refresh_taken;
      !busy && accept && cmd == sbc_pkg::CMD_REFRESH;
   endsequence
   sequence s_precharge_taken;
      !busy && accept && cmd == sbc_pkg::CMD_PRECHARGE && !i_ap;
   endsequence

   a_refresh_busy: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      s_refresh_taken |=> (glob_q == sbc_pkg::GL_REFRESHING) [*2] ##1 (glob_q == sbc_pkg::GL_NORMAL))
      else $error("refresh busy length wrong");
   a_busy_flags_illegal: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      busy && (cmd == sbc_pkg::CMD_ACTIVATE) |=> o_illegal)
      else $error("command in busy state not flagged");
   a_refresh_needs_idle: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      accept && cmd == sbc_pkg::CMD_REFRESH |-> &idle_vec)
      else $error("refresh accepted with bank not idle");
   a_precharge_to_idle: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      s_precharge_taken ##0 (bst_q[i_bank] != sbc_pkg::BK_IDLE) |=> (bst_q[$past(i_bank)] == sbc_pkg::BK_PRECHARGING)
      ##1 (bst_q[$past(i_bank, 2)] == sbc_pkg::BK_IDLE))
      else $error("precharge period wrong");
   a_idle_precharge_nop: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      s_precharge_taken ##0 (bst_q[i_bank] == sbc_pkg::BK_IDLE) |=> bst_q[$past(i_bank)] == sbc_pkg::BK_IDLE)
      else $error("idle bank changed by precharge");
   a_stop_latest_bank: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      accept && is_burst |=> o_burst_bank == $past(i_bank) && o_burst_live)
      else $error("latest burst bank not tracked");
   a_read_bus_latency: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      accept && cmd == sbc_pkg::CMD_READ ##1 !(accept && cmd == sbc_pkg::CMD_WRITE) [*2] |=> o_read_bus_q)
      else $error("read bus not taken after latency");
   a_write_cuts_read: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      accept && cmd == sbc_pkg::CMD_WRITE |=> !o_read_bus_q)
      else $error("write did not cut read");
   a_concurrent_ap: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      accept && is_burst && i_bank != 2'h0 && bst_q[0] == sbc_pkg::BK_WRITE_AP
      |=> bst_q[0] == sbc_pkg::BK_RECOVERY ##1 bst_q[0] == sbc_pkg::BK_PRECHARGING)
      else $error("write auto precharge not started after recovery");
   a_no_decode_cke_low: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      !i_cke |-> !accept)
      else $error("command taken with clock enable low");
endmodule

// >>> sbc_ctrl_model.sv
`timescale 1ns/10ps
// ****************************************************************
// Controller side: puts requested commands onto the strobe pins
// ****************************************************************
module sbc_ctrl_model
(
   input  wire logic             i_ref_clk, // Memory clock
   input  sbc_pkg::sbc_cmd_t     i_cmd,     // Requested command
   input  wire logic [1:0]       i_bank,    // Requested bank
   input  wire logic             i_ap,      // Requested address bit
   input  wire logic             i_stall,   // Hold off the event consumer
   output sbc_pkg::sbc_strobes_t o_strobes, // Chip select and strobes
   output logic [1:0]            o_bank,    // Bank address pins
   output logic                  o_ap,      // Address bit pin
   output logic                  o_ready    // Event consumer ready
);
   logic [2:0] tog_q = 3'h0;
   // Free pattern, so a deselected pin never shows a held value
   always_ff @(posedge i_ref_clk)
   begin
      tog_q <= tog_q + 3'h1;
   end
   // Strobe encoding; every requested command from CMD_NOP to CMD_BURST_STOP is driven, busy states included; the rest deselect
   always_comb
   begin
      o_bank = i_bank;
      o_ap   = i_ap;
      case (i_cmd)
         sbc_pkg::CMD_NOP:        o_strobes = 4'h7;
         sbc_pkg::CMD_ACTIVATE:   o_strobes = 4'h3;
         sbc_pkg::CMD_READ:       o_strobes = 4'h5;
         sbc_pkg::CMD_WRITE:      o_strobes = 4'h4;
         sbc_pkg::CMD_PRECHARGE:  o_strobes = 4'h2;
         sbc_pkg::CMD_REFRESH:    o_strobes = 4'h1;
         sbc_pkg::CMD_LOAD_MODE:  o_strobes = 4'h0;
         sbc_pkg::CMD_BURST_STOP: o_strobes = 4'h6;
         default:
         begin
            o_strobes = {1'b1, tog_q};
            o_bank    = ~i_bank;
            o_ap      = tog_q[0];
         end
      endcase
   end
   // Consumer can stall the event stream on demand
   assign o_ready = ~i_stall;
endmodule

// >>> sbc_map.svh
`ifndef SBC_MAP_SVH
`define SBC_MAP_SVH
// Clock period in ns at 20 MHz
`define SBC_CLK_PERIOD_NS        50
// Timing figures in ns (least times, rounded up to cycles)
`define SBC_REFRESH_CYCLE_NS     80
`define SBC_PRECHARGE_PERIOD_NS  19
`define SBC_WRITE_RECOVERY_NS    15
`define SBC_ACT_TO_ACCESS_NS     19
`define SBC_SR_EXIT_NS           80
// Mode register delay given in clocks
`define SBC_MODE_REG_DELAY_CK    2
`define SBC_CYC(ns) (((ns) + `SBC_CLK_PERIOD_NS - 1) / `SBC_CLK_PERIOD_NS)
`define SBC_REFRESH_CYCLES       `SBC_CYC(`SBC_REFRESH_CYCLE_NS)
`define SBC_PRECHARGE_CYCLES     `SBC_CYC(`SBC_PRECHARGE_PERIOD_NS)
`define SBC_WRITE_RECOVERY_CYCLES `SBC_CYC(`SBC_WRITE_RECOVERY_NS)
`define SBC_ACT_TO_ACCESS_CYCLES `SBC_CYC(`SBC_ACT_TO_ACCESS_NS)
`define SBC_SR_EXIT_CYCLES       `SBC_CYC(`SBC_SR_EXIT_NS)
// Read latency in clocks
`define SBC_READ_LATENCY         3
// Address bit that selects auto precharge or all banks
`define SBC_AP_BIT               10
`define SBC_NUM_BANKS            4
`define SBC_BUF_DEPTH            2
`endif

// >>> sbc_pkg.sv
package sbc_pkg;
   typedef enum logic [3:0] {
      CMD_INHIBIT, CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE, CMD_PRECHARGE,
      CMD_REFRESH, CMD_LOAD_MODE, CMD_BURST_STOP, CMD_DEEP_PD, CMD_IGNORED
   } sbc_cmd_t;
   typedef enum logic [3:0] {
      BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READ, BK_WRITE,
      BK_READ_AP, BK_WRITE_AP, BK_RECOVERY, BK_PRECHARGING
   } sbc_bank_state_t;
   typedef enum logic [1:0] {
      GL_NORMAL, GL_REFRESHING, GL_MODE_ACCESS, GL_PRECHARGE_ALL
   } sbc_glob_state_t;
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } sbc_strobes_t;
   typedef struct packed {
      sbc_cmd_t   cmd;
      logic [1:0] bank;
      logic       ap;
   } sbc_event_t;
endpackage

// >>> tb_sbc_bank_rules.sv
`timescale 1ns/10ps
module tb_sbc_bank_rules;
   typedef struct packed {
      sbc_pkg::sbc_cmd_t cmd;
      logic [1:0]        bk;
      logic              ap;
      logic [15:0]       st;
      logic [1:0]        gl;
   } sbc_row_t;
   localparam sbc_pkg::sbc_cmd_t AC = sbc_pkg::CMD_ACTIVATE, NP = sbc_pkg::CMD_NOP, RD = sbc_pkg::CMD_READ,
      WR = sbc_pkg::CMD_WRITE, PR = sbc_pkg::CMD_PRECHARGE, RF = sbc_pkg::CMD_REFRESH,
      LM = sbc_pkg::CMD_LOAD_MODE, BS = sbc_pkg::CMD_BURST_STOP, IN = sbc_pkg::CMD_INHIBIT;
   logic clk = 1'b0, resetn = 1'b0, cke = 1'b1, ap = 1'b0, stall = 1'b0, sr_exit = 1'b0, m_ap, ready;
   logic [1:0] bk = 2'h0, m_bank;
   sbc_pkg::sbc_cmd_t cmd = sbc_pkg::CMD_NOP;
   sbc_pkg::sbc_strobes_t strobes;
   sbc_pkg::sbc_event_t evt;
   logic evt_valid, all_idle, illegal, burst_live, rbus;
   logic [15:0] bank_state;
   logic [1:0] glob, burst_bank, rbus_bank;
   int n_errors = 0, checked = 0;
   sbc_row_t rows[$];
   sbc_ctrl_model u_ctrl (.i_ref_clk(clk), .i_cmd(cmd), .i_bank(bk), .i_ap(ap), .i_stall(stall),
      .o_strobes(strobes), .o_bank(m_bank), .o_ap(m_ap), .o_ready(ready));
   sbc_bank_rules dut (.i_ref_clk(clk), .i_resetn(resetn), .i_cke(cke), .i_strobes(strobes),
      .i_bank(m_bank), .i_ap(m_ap), .i_sr_exit(sr_exit), .i_evt_ready(ready), .o_evt_valid(evt_valid),
      .o_evt(evt), .o_bank_state(bank_state), .o_glob_state(glob), .o_all_idle(all_idle),
      .o_illegal(illegal), .o_burst_bank(burst_bank), .o_burst_live(burst_live),
      .o_read_bus_q(rbus), .o_read_bus_bank(rbus_bank));
   // Clock at 20 MHz
   always #25 clk = ~clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked = checked + 1;
      if (seen !== exp)
      begin
         n_errors = n_errors + 1;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic add(input sbc_pkg::sbc_cmd_t c, input logic [1:0] b, input logic a,
                      input logic [15:0] s, input logic [1:0] g);
      rows.push_back('{c, b, a, s, g});
   endtask
   // One command request per clock, launched just after the edge
   task automatic cyc(input sbc_pkg::sbc_cmd_t c, input logic [1:0] b, input logic a);
      @(posedge clk);
      cmd <= c;
      bk  <= b;
      ap  <= a;
   endtask
   // Watchdog: the whole run needs well under 200 cycles
   initial
   begin
      repeat (2000) @(posedge clk);
      n_errors = n_errors + 1;
      tally_and_finish();
   end
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      add(AC, 2'h0, 1'b0, 16'h0001, 2'h0);
      add(NP, 2'h0, 1'b0, 16'h0002, 2'h0);
      add(AC, 2'h1, 1'b0, 16'h0012, 2'h0);
      add(IN, 2'h2, 1'b0, 16'h0022, 2'h0);
      add(RD, 2'h0, 1'b1, 16'h0025, 2'h0);
      add(RD, 2'h1, 1'b0, 16'h0038, 2'h0);
      add(NP, 2'h0, 1'b0, 16'h0030, 2'h0);
      add(WR, 2'h1, 1'b0, 16'h0040, 2'h0);
      add(BS, 2'h0, 1'b0, 16'h0020, 2'h0);
      add(PR, 2'h0, 1'b0, 16'h0020, 2'h0);
      add(AC, 2'h0, 1'b0, 16'h0021, 2'h0);
      add(NP, 2'h0, 1'b0, 16'h0022, 2'h0);
      add(WR, 2'h0, 1'b1, 16'h0026, 2'h0);
      add(WR, 2'h1, 1'b0, 16'h0047, 2'h0);
      add(NP, 2'h0, 1'b0, 16'h0048, 2'h0);
      add(NP, 2'h0, 1'b0, 16'h0040, 2'h0);
      add(PR, 2'h1, 1'b0, 16'h0080, 2'h0);
      add(NP, 2'h0, 1'b0, 16'h0000, 2'h0);
      add(RF, 2'h0, 1'b0, 16'h0000, 2'h1);
      add(NP, 2'h0, 1'b0, 16'h0000, 2'h1);
      add(NP, 2'h0, 1'b0, 16'h0000, 2'h0);
      add(LM, 2'h0, 1'b0, 16'h0000, 2'h2);
      add(AC, 2'h2, 1'b0, 16'h0000, 2'h2);
      add(NP, 2'h0, 1'b0, 16'h0000, 2'h0);
      add(PR, 2'h0, 1'b1, 16'h0000, 2'h3);
      add(NP, 2'h0, 1'b0, 16'h0000, 2'h0);
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      @(negedge clk);
      check({bank_state, glob, all_idle, evt_valid, illegal}, 32'h00000004);
      $display("Reset values done");
      // Table rows: row i is launched, then row i-1 is judged
      for (int i = 0; i <= rows.size(); i++)
      begin
         @(posedge clk);
         cmd <= (i < rows.size()) ? rows[i].cmd : NP;
         bk  <= (i < rows.size()) ? rows[i].bk : 2'h0;
         ap  <= (i < rows.size()) ? rows[i].ap : 1'b0;
         @(negedge clk);
         if (i > 0)
            check({bank_state, glob}, {rows[i-1].st, rows[i-1].gl});
      end
      $display("Command table done");
      // Clock enable low, then first high edge: both ignored
      @(posedge clk);
      cke <= 1'b0;
      cmd <= AC;
      @(posedge clk);
      cke <= 1'b1;
      cyc(NP, 2'h0, 1'b0);
      @(negedge clk);
      check(bank_state, 16'h0000);
      // Read to an idle bank is refused
      cyc(RD, 2'h0, 1'b0);
      cyc(NP, 2'h0, 1'b0);
      @(negedge clk);
      check({illegal, bank_state}, 17'h10000);
      $display("Enable and refusal done");
      // Stalled consumer: two words kept, the third dropped
      cyc(AC, 2'h2, 1'b0);
      stall <= 1'b1;
      cyc(AC, 2'h3, 1'b0);
      cyc(AC, 2'h0, 1'b0);
      cyc(NP, 2'h0, 1'b0);
      @(negedge clk);
      check(bank_state, 16'h2201);
      @(posedge clk);
      stall <= 1'b0;
      @(negedge clk);
      check({evt_valid, evt}, {1'b1, AC, 2'h2, 1'b0});
      @(negedge clk);
      check({evt_valid, evt}, {1'b1, AC, 2'h3, 1'b0});
      @(negedge clk);
      check(evt_valid, 1'b0);
      $display("Event buffer done");
      // Back-to-back reads: the second takes the bus one edge later
      cyc(RD, 2'h2, 1'b0);
      cyc(RD, 2'h3, 1'b0);
      cyc(NP, 2'h0, 1'b0);
      @(posedge clk);
      @(negedge clk);
      check({rbus, rbus_bank}, 3'h6);
      @(negedge clk);
      check({rbus, rbus_bank}, 3'h7);
      check({burst_live, burst_bank}, 3'h7);
      // Self refresh exit: exit edge and the exit time ignore commands
      @(posedge clk);
      sr_exit <= 1'b1;
      cmd     <= AC;
      bk      <= 2'h1;
      @(posedge clk);
      sr_exit <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      check(bank_state[7:4], 4'h0);
      cyc(NP, 2'h0, 1'b0);
      @(negedge clk);
      check(bank_state[7:4], 4'h1);
      // Refresh with open banks is refused
      cyc(RF, 2'h0, 1'b0);
      cyc(NP, 2'h0, 1'b0);
      @(negedge clk);
      check({illegal, glob}, 3'h4);
      $display("Read bus and refresh guard done");
      tally_and_finish();
   end
endmodule
